// ---- src/led_pwm_group_control.sv ----
// register bank and pwm output control for an eight channel led sink driver
// Functional notes
// (R1) top three mode bits echo pointer increment flags
// (R2) sleep bit stops oscillator, resets to one
// (R3) host waits for oscillator start after wake
// (R4) sleep disables group dimming and blinking
// (R5) three group address enables, reset zero
// (R6) broadcast enable bit resets to one
// (R7) error clear bit clears flags while set
// (R8) group function bit selects dim or blink
// (R9) update timing bit: stop or acknowledge
// (R10) reserved secondary mode bits read zero
// (R11) eight 97 kHz pwm, duty value/256
// (R12) individual pwm only in states 10, 11
// (R13) dimming gates with 190 Hz group signal
// (R14) group duty value/256, only state 11
// (R15) blinking uses period and duty registers
// (R16) blink period is (value+1)/24 seconds
// (R17) output states packed four per register
// (R18) state 00 off, state 01 fully on
// (R19) group address fixed bits and defaults
// (R20) control byte gives pointer and increment
// (R21) host clears then rearms error flags
// (R22) read-only writes ignored, reads show shadow
// (R23) deferred updates applied together at stop
`timescale 1ns/1ps
`include "led_pwm_defs.svh"

module led_pwm_group_control #(
   parameter int CHANNELS = 8,
   parameter int BLINK_STEP_CYC = `BLINK_STEP_CYC
) (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic [4:0] reg_index_in,
   input wire logic reg_write_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_read_in,
   output logic [7:0] reg_rdata_out,
   input wire logic [2:0] increment_flags_in,
   input wire logic bus_stop_in,
   input wire logic [7:0] error_status_in,
   output logic [7:0] led_sink_on_out,
   output led_pwm_pkg::mode_s mode_out,
   output led_pwm_pkg::addr_cfg_s addr_cfg_out
);

   localparam logic [15:0] IND_LAST = 16'(`IND_STEP_CYC - 1);
   localparam logic [15:0] DIM_LAST = 16'(`DIM_STEP_CYC - 1);
   localparam logic [15:0] BLINK_LAST = 16'(BLINK_STEP_CYC - 1);

   function automatic logic duty_high(input logic [7:0] phase, input logic [7:0] duty);
      duty_high = phase < duty;
   endfunction

   // mode and address state
   logic [4:0] primary_low;
   logic [7:0] secondary_mode_control;
   logic [3:0] group_address_one;
   logic [3:0] group_address_two;
   logic [3:0] group_address_three;
   logic [3:0] broadcast_address;
   logic [7:0] output_gain_config;
   logic [7:0] channel_error_flags;

   // shadow copies seen by the bus, active copies seen by the pwm
   logic [7:0] shadow_bright [CHANNELS];
   logic [7:0] active_bright [CHANNELS];
   logic [7:0] shadow_group_duty;
   logic [7:0] active_group_duty;
   logic [7:0] shadow_blink_period;
   logic [7:0] active_blink_period;
   logic [15:0] shadow_state;
   logic [15:0] active_state;

   logic sleep;
   logic update_on_ack;
   logic blink_mode;
   logic apply_pending;
   logic apply_now;

   assign sleep = primary_low[`BIT_SLEEP];
   assign update_on_ack = secondary_mode_control[`BIT_UPDATE_TIMING];
   assign blink_mode = secondary_mode_control[`BIT_GROUP_FUNC];

   // primary and secondary mode; increment bits are never stored here
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         primary_low <= `RST_PRIMARY_LOW; // (R2) (R5) (R6)
         secondary_mode_control <= 8'h00; // (R7)
      end else if (reg_write_in) begin
         if (reg_index_in == `OFS_PRIMARY_MODE) begin
            primary_low <= reg_wdata_in[4:0]; // (R1) (R22)
         end
         if (reg_index_in == `OFS_SECONDARY_MODE) begin
            secondary_mode_control <= reg_wdata_in & 8'ha8; // (R10) (R22)
         end
      end
   end

   // address and gain configuration
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         group_address_one <= `RST_SUB_ONE; // (R19)
         group_address_two <= `RST_SUB_TWO;
         group_address_three <= `RST_SUB_THREE;
         broadcast_address <= `RST_BROADCAST;
         output_gain_config <= `RST_GAIN;
      end else if (reg_write_in) begin
         unique case (reg_index_in)
            `OFS_GROUP_ADDR_ONE: group_address_one <= reg_wdata_in[4:1]; // (R19)
            `OFS_GROUP_ADDR_TWO: group_address_two <= reg_wdata_in[4:1];
            `OFS_GROUP_ADDR_THREE: group_address_three <= reg_wdata_in[4:1];
            `OFS_BROADCAST_ADDR: broadcast_address <= reg_wdata_in[4:1];
            `OFS_GAIN_CONFIG: output_gain_config <= reg_wdata_in;
            default: begin
            end
         endcase
      end
   end

   // error flags: a zero marks an error and stays until cleared
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         channel_error_flags <= `RST_ERR_FLAGS;
      end else if (secondary_mode_control[`BIT_ERR_CLEAR]) begin
         channel_error_flags <= `RST_ERR_FLAGS; // (R7)
      end else begin
         channel_error_flags <= channel_error_flags & error_status_in;
      end
   end

   // shadow writes for the output-affecting registers
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < CHANNELS; i++) begin
            shadow_bright[i] <= `RST_BRIGHT;
         end
         shadow_group_duty <= `RST_GROUP_DUTY;
         shadow_blink_period <= `RST_BLINK_PERIOD;
         shadow_state <= {2{`RST_STATE}};
      end else if (reg_write_in) begin
         for (int i = 0; i < CHANNELS; i++) begin
            if (reg_index_in == 5'(`OFS_BRIGHT_FIRST + i)) begin
               shadow_bright[i] <= reg_wdata_in; // (R22)
            end
         end
         if (reg_index_in == `OFS_GROUP_DUTY) begin
            shadow_group_duty <= reg_wdata_in;
         end
         if (reg_index_in == `OFS_BLINK_PERIOD) begin
            shadow_blink_period <= reg_wdata_in;
         end
         if (reg_index_in == `OFS_STATE_LOW) begin
            shadow_state[7:0] <= reg_wdata_in; // (R17)
         end
         if (reg_index_in == `OFS_STATE_HIGH) begin
            shadow_state[15:8] <= reg_wdata_in; // (R17)
         end
      end
   end

   // a write at acknowledge applies on the following cycle
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         apply_pending <= 1'b0;
      end else begin
         apply_pending <= reg_write_in && reg_index_in >= `OFS_BRIGHT_FIRST
            && reg_index_in <= `OFS_STATE_HIGH; // (R9)
      end
   end

   assign apply_now = update_on_ack ? apply_pending : bus_stop_in; // (R9)

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < CHANNELS; i++) begin
            active_bright[i] <= `RST_BRIGHT;
         end
         active_group_duty <= `RST_GROUP_DUTY;
         active_blink_period <= `RST_BLINK_PERIOD;
         active_state <= {2{`RST_STATE}};
      end else if (apply_now) begin
         for (int i = 0; i < CHANNELS; i++) begin
            active_bright[i] <= shadow_bright[i]; // (R23)
         end
         active_group_duty <= shadow_group_duty; // (R23)
         active_blink_period <= shadow_blink_period;
         active_state <= shadow_state;
      end
   end

   // individual pwm time base
   logic [15:0] ind_div;
   logic [7:0] ind_phase;

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ind_div <= 16'h0000;
         ind_phase <= 8'h00;
      end else if (sleep) begin
         ind_div <= 16'h0000;
         ind_phase <= 8'h00;
      end else if (ind_div == IND_LAST) begin
         ind_div <= 16'h0000;
         ind_phase <= ind_phase + 8'h01; // (R11)
      end else begin
         ind_div <= ind_div + 16'h0001;
      end
   end

   // group time base: fixed 190 Hz for dimming, programmable for blinking
   logic [15:0] grp_div;
   logic [7:0] blink_sub;
   logic [7:0] grp_phase;
   logic grp_tick;

   // at or past the end, so a mode switch never strands the divider
   assign grp_tick = grp_div >= (blink_mode ? BLINK_LAST : DIM_LAST); // (R13) (R15)

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         grp_div <= 16'h0000;
         blink_sub <= 8'h00;
         grp_phase <= 8'h00;
      end else if (sleep) begin
         grp_div <= 16'h0000; // (R4)
         blink_sub <= 8'h00;
         grp_phase <= 8'h00;
      end else if (grp_tick) begin
         grp_div <= 16'h0000;
         if (!blink_mode) begin
            grp_phase <= grp_phase + 8'h01; // (R13)
         end else if (blink_sub >= active_blink_period) begin
            blink_sub <= 8'h00;
            grp_phase <= grp_phase + 8'h01; // (R16)
         end else begin
            blink_sub <= blink_sub + 8'h01; // (R16)
         end
      end else begin
         grp_div <= grp_div + 16'h0001;
      end
   end

   // per channel output decision
   logic group_on;

   assign group_on = !sleep && duty_high(grp_phase, active_group_duty); // (R4) (R14)

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         led_sink_on_out <= 8'h00;
      end else begin
         for (int i = 0; i < CHANNELS; i++) begin
            unique case (led_pwm_pkg::out_state_e'(active_state[2*i +: 2]))
               led_pwm_pkg::out_off: led_sink_on_out[i] <= 1'b0; // (R18)
               led_pwm_pkg::out_full: led_sink_on_out[i] <= 1'b1; // (R18)
               led_pwm_pkg::out_individual: led_sink_on_out[i] <= !sleep
                  && duty_high(ind_phase, active_bright[i]); // (R12)
               led_pwm_pkg::out_group: led_sink_on_out[i] <= group_on
                  && duty_high(ind_phase, active_bright[i]); // (R12) (R14)
            endcase
         end
      end
   end

   // register read port, data one cycle after the strobe
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_read_in) begin
         reg_rdata_out <= 8'h00;
         unique case (reg_index_in)
            `OFS_PRIMARY_MODE: reg_rdata_out <= {increment_flags_in, primary_low}; // (R1) (R20)
            `OFS_SECONDARY_MODE: reg_rdata_out <= secondary_mode_control; // (R10)
            `OFS_GROUP_DUTY: reg_rdata_out <= shadow_group_duty; // (R22)
            `OFS_BLINK_PERIOD: reg_rdata_out <= shadow_blink_period;
            `OFS_STATE_LOW: reg_rdata_out <= shadow_state[7:0];
            `OFS_STATE_HIGH: reg_rdata_out <= shadow_state[15:8];
            `OFS_GROUP_ADDR_ONE: reg_rdata_out <= {`ADDR_FIXED_HIGH, group_address_one, 1'b0}; // (R19)
            `OFS_GROUP_ADDR_TWO: reg_rdata_out <= {`ADDR_FIXED_HIGH, group_address_two, 1'b0};
            `OFS_GROUP_ADDR_THREE: reg_rdata_out <= {`ADDR_FIXED_HIGH, group_address_three, 1'b0};
            `OFS_BROADCAST_ADDR: reg_rdata_out <= {`ADDR_FIXED_HIGH, broadcast_address, 1'b0};
            `OFS_GAIN_CONFIG: reg_rdata_out <= output_gain_config;
            `OFS_ERROR_FLAGS: reg_rdata_out <= channel_error_flags;
            default: begin
               for (int i = 0; i < CHANNELS; i++) begin
                  if (reg_index_in == 5'(`OFS_BRIGHT_FIRST + i)) begin
                     reg_rdata_out <= shadow_bright[i]; // (R22)
                  end
               end
            end
         endcase
      end
   end

   // configuration seen by the address matcher and analog side
   always_comb begin
      mode_out.sleep = sleep; // (R2)
      mode_out.error_flag_clear = secondary_mode_control[`BIT_ERR_CLEAR]; // (R7)
      mode_out.group_function_select = blink_mode; // (R8)
      mode_out.update_timing_select = update_on_ack;
      addr_cfg_out.group_enable = {primary_low[`BIT_SUB_ONE], primary_low[`BIT_SUB_TWO],
         primary_low[`BIT_SUB_THREE]}; // (R5)
      addr_cfg_out.broadcast_enable = primary_low[`BIT_BROADCAST]; // (R6)
      addr_cfg_out.group_address_one = {`ADDR_FIXED_HIGH, group_address_one};
      addr_cfg_out.group_address_two = {`ADDR_FIXED_HIGH, group_address_two};
      addr_cfg_out.group_address_three = {`ADDR_FIXED_HIGH, group_address_three};
      addr_cfg_out.broadcast_address = {`ADDR_FIXED_HIGH, broadcast_address};
      addr_cfg_out.output_gain_config = output_gain_config;
   end

endmodule

// ---- src/led_pwm_defs.svh ----
// register offsets, field positions, reset values and timing figures
`ifndef LED_PWM_DEFS_SVH
`define LED_PWM_DEFS_SVH

`define OFS_PRIMARY_MODE 5'h00
`define OFS_SECONDARY_MODE 5'h01
`define OFS_BRIGHT_FIRST 5'h02
`define OFS_BRIGHT_LAST 5'h09
`define OFS_GROUP_DUTY 5'h0a
`define OFS_BLINK_PERIOD 5'h0b
`define OFS_STATE_LOW 5'h0c
`define OFS_STATE_HIGH 5'h0d
`define OFS_GROUP_ADDR_ONE 5'h0e
`define OFS_GROUP_ADDR_TWO 5'h0f
`define OFS_GROUP_ADDR_THREE 5'h10
`define OFS_BROADCAST_ADDR 5'h11
`define OFS_GAIN_CONFIG 5'h12
`define OFS_ERROR_FLAGS 5'h13

`define BIT_SLEEP 4
`define BIT_SUB_ONE 3
`define BIT_SUB_TWO 2
`define BIT_SUB_THREE 1
`define BIT_BROADCAST 0
`define BIT_ERR_CLEAR 7
`define BIT_GROUP_FUNC 5
`define BIT_UPDATE_TIMING 3

`define RST_PRIMARY_LOW 5'h11
`define RST_BRIGHT 8'h00
`define RST_GROUP_DUTY 8'hff
`define RST_BLINK_PERIOD 8'h00
`define RST_STATE 8'h00
`define RST_SUB_ONE 4'h9
`define RST_SUB_TWO 4'ha
`define RST_SUB_THREE 4'hc
`define RST_BROADCAST 4'h8
`define RST_GAIN 8'hff
`define RST_ERR_FLAGS 8'hff
`define ADDR_FIXED_HIGH 3'h4

`define CLK_HZ 50000000
`define IND_PWM_HZ 97000
`define DIM_HZ 190
`define BLINK_DIV 24
`define PWM_STEPS 256
`define IND_STEP_CYC (`CLK_HZ / (`IND_PWM_HZ * `PWM_STEPS))
`define DIM_STEP_CYC (`CLK_HZ / (`DIM_HZ * `PWM_STEPS))
`define BLINK_STEP_CYC (`CLK_HZ / (`BLINK_DIV * `PWM_STEPS))

`endif

// ---- src/led_pwm_pkg.sv ----
// types shared by the led pwm register bank
package led_pwm_pkg;

   typedef enum logic [1:0] {
      out_off = 2'b00,
      out_full = 2'b01,
      out_individual = 2'b10,
      out_group = 2'b11
   } out_state_e;

   typedef struct packed {
      logic [2:0] group_enable;
      logic broadcast_enable;
      logic [6:0] group_address_one;
      logic [6:0] group_address_two;
      logic [6:0] group_address_three;
      logic [6:0] broadcast_address;
      logic [7:0] output_gain_config;
   } addr_cfg_s;

   typedef struct packed {
      logic sleep;
      logic error_flag_clear;
      logic group_function_select;
      logic update_timing_select;
   } mode_s;

endpackage

// ---- sim/led_pwm_group_control_chk.sv ----
// port-level assertions for the led pwm register bank
`timescale 1ns/1ps
module led_pwm_group_control_chk (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic [4:0] reg_index_in,
   input wire logic reg_write_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_read_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic [2:0] increment_flags_in,
   input wire logic bus_stop_in,
   input wire logic [7:0] error_status_in,
   input wire logic [7:0] led_sink_on_out,
   input wire led_pwm_pkg::mode_s mode_out,
   input wire led_pwm_pkg::addr_cfg_s addr_cfg_out
);
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_in);
   property p_unmapped_read;
      reg_read_in && reg_index_in > 5'h13 |=> reg_rdata_out == 8'h00;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");
   property p_flags_echo;
      reg_read_in && reg_index_in == 5'h00 |=> reg_rdata_out[7:5] == $past(increment_flags_in);
   endproperty
   a_flags_echo: assert property (p_flags_echo) else $error("mode flags not echoed");
   property p_reserved_zero;
      reg_read_in && reg_index_in == 5'h01 |=> (reg_rdata_out & 8'h57) == 8'h00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");
   property p_addr_fixed;
      reg_read_in && reg_index_in inside {[5'h0e:5'h11]} |=>
         reg_rdata_out[7:5] == 3'h4 && !reg_rdata_out[0];
   endproperty
   a_addr_fixed: assert property (p_addr_fixed) else $error("address fixed bits wrong");
   property p_mode_one_write;
      reg_write_in && reg_index_in == 5'h00 |=> mode_out.sleep == $past(reg_wdata_in[4]) &&
         addr_cfg_out.broadcast_enable == $past(reg_wdata_in[0]) &&
         addr_cfg_out.group_enable == $past(reg_wdata_in[3:1]);
   endproperty
   a_mode_one_write: assert property (p_mode_one_write) else $error("mode one not taken");
   property p_mode_two_write;
      reg_write_in && reg_index_in == 5'h01 |=>
         {mode_out.error_flag_clear, mode_out.group_function_select} ==
         {$past(reg_wdata_in[7]), $past(reg_wdata_in[5])} &&
         mode_out.update_timing_select == $past(reg_wdata_in[3]);
   endproperty
   a_mode_two_write: assert property (p_mode_two_write) else $error("mode two not taken");
   property p_clear_holds;
      mode_out.error_flag_clear && $past(mode_out.error_flag_clear) && reg_read_in &&
         reg_index_in == 5'h13 |=> reg_rdata_out == 8'hff;
   endproperty
   a_clear_holds: assert property (p_clear_holds) else $error("flags not cleared");
   property p_shadow_read;
      reg_write_in && reg_index_in inside {[5'h02:5'h0d]} ##1 !reg_write_in ##1
         reg_read_in && !reg_write_in && reg_index_in == $past(reg_index_in, 2) |=>
         reg_rdata_out == $past(reg_wdata_in, 3);
   endproperty
   a_shadow_read: assert property (p_shadow_read) else $error("shadow read mismatch");
endmodule

bind led_pwm_group_control led_pwm_group_control_chk u_chk (
   .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .reg_index_in(reg_index_in),
   .reg_write_in(reg_write_in), .reg_wdata_in(reg_wdata_in), .reg_read_in(reg_read_in),
   .reg_rdata_out(reg_rdata_out), .increment_flags_in(increment_flags_in),
   .bus_stop_in(bus_stop_in), .error_status_in(error_status_in),
   .led_sink_on_out(led_sink_on_out), .mode_out(mode_out), .addr_cfg_out(addr_cfg_out)
);

// ---- sim/led_pwm_host.sv ----
// host model driving the register port of the led pwm block
`timescale 1ns/1ps
module led_pwm_host (
   input wire logic ref_clk_in,
   output logic [4:0] reg_index_out,
   output logic reg_write_out,
   output logic [7:0] reg_wdata_out,
   output logic reg_read_out,
   input wire logic [7:0] reg_rdata_in,
   output logic [2:0] increment_flags_out,
   output logic bus_stop_out,
   output logic [7:0] error_status_out
);
   initial begin
      reg_index_out = 5'h00;
      reg_write_out = 1'b0;
      reg_wdata_out = 8'h00;
      reg_read_out = 1'b0;
      increment_flags_out = 3'h0;
      bus_stop_out = 1'b0;
      error_status_out = 8'hff;
   end
   task automatic wr(input logic [4:0] idx, input logic [7:0] data);
      @(posedge ref_clk_in);
      #1;
      reg_index_out = idx;
      reg_wdata_out = data;
      reg_write_out = 1'b1;
      @(posedge ref_clk_in);
      #1;
      reg_write_out = 1'b0;
      // released data no longer carries the byte
      reg_wdata_out = ~data;
   endtask
   task automatic rd(input logic [4:0] idx, output logic [7:0] data);
      @(posedge ref_clk_in);
      #1;
      reg_index_out = idx;
      reg_read_out = 1'b1;
      @(posedge ref_clk_in);
      #1;
      reg_read_out = 1'b0;
      data = reg_rdata_in;
   endtask
   task automatic set_flags(input logic [2:0] flags);
      increment_flags_out = flags;
   endtask
   task automatic stop();
      @(posedge ref_clk_in);
      #1;
      bus_stop_out = 1'b1;
      @(posedge ref_clk_in);
      #1;
      bus_stop_out = 1'b0;
   endtask
   task automatic err_pulse(input logic [7:0] status);
      @(posedge ref_clk_in);
      #1;
      error_status_out = status;
      @(posedge ref_clk_in);
      #1;
      error_status_out = 8'hff;
   endtask
   // oscillator start-up after wake
   task automatic wake_wait();
      repeat (25000) @(posedge ref_clk_in);
   endtask
endmodule

// ---- sim/led_pwm_group_control_tb_top.sv ----
// self-checking bench for the led pwm register bank
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
   begin \
      n_checks++; \
      if ((got) !== (exp)) begin \
         $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); \
         err_count++; \
      end \
   end
module led_pwm_group_control_tb_top;
   logic ref_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [4:0] reg_index_in;
   logic reg_write_in, reg_read_in, bus_stop_in;
   logic [7:0] reg_wdata_in, reg_rdata_out, error_status_in, led_sink_on_out, d;
   logic [2:0] increment_flags_in;
   led_pwm_pkg::mode_s mode_out;
   led_pwm_pkg::addr_cfg_s addr_cfg_out;
   int err_count = 0;
   int n_checks = 0;
   int cyc = 0;
   int hi [8];
   logic [7:0] rst_tab [22] = '{8'h11, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h92, 8'h94, 8'h98, 8'h90, 8'hff, 8'hff,
      8'h00, 8'h00};
   always #10 ref_clk_in = ~ref_clk_in;
   led_pwm_host host (.ref_clk_in(ref_clk_in), .reg_index_out(reg_index_in),
      .reg_write_out(reg_write_in), .reg_wdata_out(reg_wdata_in), .reg_read_out(reg_read_in),
      .reg_rdata_in(reg_rdata_out), .increment_flags_out(increment_flags_in),
      .bus_stop_out(bus_stop_in), .error_status_out(error_status_in));
   led_pwm_group_control #(.BLINK_STEP_CYC(4)) dut (.ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in), .reg_index_in(reg_index_in), .reg_write_in(reg_write_in),
      .reg_wdata_in(reg_wdata_in), .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
      .increment_flags_in(increment_flags_in), .bus_stop_in(bus_stop_in),
      .error_status_in(error_status_in), .led_sink_on_out(led_sink_on_out),
      .mode_out(mode_out), .addr_cfg_out(addr_cfg_out));
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // counts high cycles per channel over a window
   task automatic measure(input int n);
      for (int c = 0; c < 8; c++) hi[c] = 0;
      repeat (n) begin
         @(posedge ref_clk_in);
         #1;
         for (int c = 0; c < 8; c++) if (led_sink_on_out[c] === 1'b1) hi[c]++;
      end
   endtask
   always @(posedge ref_clk_in) begin
      cyc++;
      if (cyc == 60000) begin
         err_count++;
         finish_test();
      end
   end
   initial begin
      repeat (20) @(posedge ref_clk_in);
      #1;
      rst_n_in = 1'b1;
      for (int i = 0; i < 22; i++) begin
         host.rd(i[4:0], d);
         `CHK("reset value", rst_tab[i], d);
      end
      @(posedge ref_clk_in);
      #1;
      host.set_flags(3'h5);
      host.wr(5'h00, 8'hef);
      host.rd(5'h00, d);
      `CHK("primary mode", 8'haf, d);
      host.wake_wait();
      host.wr(5'h01, 8'hff);
      host.rd(5'h01, d);
      `CHK("secondary mode", 8'ha8, d);
      host.err_pulse(8'hfb);
      host.rd(5'h13, d);
      `CHK("flags while clearing", 8'hff, d);
      host.wr(5'h01, 8'h00);
      host.err_pulse(8'hfb);
      host.rd(5'h13, d);
      `CHK("flag latched", 8'hfb, d);
      host.wr(5'h01, 8'h80);
      host.wr(5'h01, 8'h00);
      host.wr(5'h13, 8'h00);
      host.rd(5'h13, d);
      `CHK("flags rearmed", 8'hff, d);
      host.wr(5'h0e, 8'hff);
      host.rd(5'h0e, d);
      `CHK("group address", 8'h9e, d);
      `CHK("group address pins", 7'h4f, addr_cfg_out.group_address_one);
      host.wr(5'h02, 8'h80);
      host.wr(5'h04, 8'hff);
      host.wr(5'h0c, 8'h2a);
      `CHK("held until stop", 8'h00, led_sink_on_out);
      host.rd(5'h0c, d);
      `CHK("pending state", 8'h2a, d);
      host.stop();
      repeat (3) @(posedge ref_clk_in);
      measure(512);
      `CHK("half duty", 256, hi[0]);
      `CHK("zero duty", 0, hi[1]);
      `CHK("full duty", 510, hi[2]);
      `CHK("state off", 0, hi[3]);
      host.wr(5'h01, 8'h20);
      host.wr(5'h05, 8'hff);
      host.wr(5'h0a, 8'h40);
      host.wr(5'h0b, 8'h01);
      host.wr(5'h0c, 8'hea);
      host.stop();
      repeat (3) @(posedge ref_clk_in);
      measure(2048);
      `CHK("blink gated", 510, hi[3]);
      `CHK("blink ignores state 10", 2040, hi[2]);
      host.wr(5'h01, 8'h28);
      host.wr(5'h0c, 8'he6);
      repeat (3) @(posedge ref_clk_in);
      #1;
      `CHK("ack update", 1'b1, led_sink_on_out[1]);
      host.wr(5'h01, 8'h08);
      host.wr(5'h0a, 8'h00);
      repeat (3) @(posedge ref_clk_in);
      measure(512);
      `CHK("dim gated", 0, hi[3]);
      `CHK("dim leaves state 10", 510, hi[2]);
      host.wr(5'h0a, 8'hff);
      host.wr(5'h00, 8'h10);
      repeat (4) @(posedge ref_clk_in);
      measure(2048);
      `CHK("sleep full on", 2048, hi[1]);
      `CHK("sleep group off", 0, hi[3]);
      `CHK("sleep pwm off", 0, hi[0]);
      finish_test();
   end
endmodule
